/* File: verilog/scsp_strap_capture.sv */
`timescale 1ns/100ps
// What this block does
// - Strap low: serial data pin serves an external SMBus host as slave.
// - Strap high: serial clock and data pins master an external EEPROM.
// - Mode strap sampled at reset release; 1 is I2C master, 0 SMBus slave.
// - With status enable, mode strap pin shows SuperSpeed suspend, 1 suspended.
// - Power strap sampled at reset release; 0 enables power switching and charge outputs.
// - With power management, NPORT (1 to 4, default four) power-control and as many charge-enable outputs drive ports.
// - In SMBus mode, slave address bit 1 comes from the power strap.
// - With status enable, power strap pin shows 1 while SuperSpeed connected.
// - Polarity strap sampled at reset release; 0 active low, 1 active high.
module scsp_strap_capture #(
   parameter int NPORT = scsp_pkg::NUM_PORTS
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   // Strap pins, input side
   input  wire logic             mgmt_mode_strap,
   input  wire logic             full_power_mgmt_strap_n,
   input  wire logic             power_ctrl_polarity_strap,
   // Strap pins, reused as status outputs
   output logic                  mgmt_mode_pin_out,
   output logic                  mgmt_mode_pin_oe,
   output logic                  full_power_mgmt_pin_out,
   output logic                  full_power_mgmt_pin_oe,
   // Hub core status and control
   input  wire logic             status_output_enable,
   input  wire logic             ss_suspended,
   input  wire logic             ss_connected,
   input  wire logic [NPORT-1:0] port_power_request,
   input  wire logic [NPORT-1:0] port_charge_request,
   // Serial management engine, master side
   input  wire logic             master_scl_drive_low,
   input  wire logic             master_sda_drive_low,
   // Serial management engine, slave side
   input  wire logic             slave_sda_drive_low,
   // Serial management pins
   output logic                  scl_pin_out,
   output logic                  scl_pin_oe,
   output logic                  sda_pin_out,
   output logic                  sda_pin_oe,
   // Captured configuration
   output logic                  i2c_master_mode,
   output logic                  smbus_slave_mode,
   output logic                  power_switching_enabled,
   output logic                  power_ctrl_active_high,
   output logic [6:0]            slave_addr,
   output logic                  straps_valid,
   // Downstream port power
   output logic [NPORT-1:0]      port_power_enable_out,
   output logic [NPORT-1:0]      battery_charge_enable_out
);
   import scsp_pkg::*;

   // The pin budget has four power-control outputs
   if (NPORT < 1 || NPORT > 4) begin : g_nport_check
      $error("NPORT must be 1 to 4");
   end

   scsp_state_t state;
   logic [2:0]  strap_s1;
   logic [2:0]  strap_s2;
   logic        mgmt_mode;
   logic        fpm_n;
   logic        polarity;
   logic        status_on;

   // Straps are asynchronous pins, synchronised before use
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         strap_s1 <= 3'h0;
         strap_s2 <= 3'h0;
      end else begin
         strap_s1 <= {mgmt_mode_strap, full_power_mgmt_strap_n, power_ctrl_polarity_strap};
         strap_s2 <= strap_s1;
      end
   end

   // Capture waits two edges so both synchroniser stages hold the pin level, not their reset value
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= SCSP_RESET;
      end else begin
         unique case (state)
            SCSP_RESET:   state <= SCSP_FILL;
            SCSP_FILL:    state <= SCSP_CAPTURE;
            SCSP_CAPTURE: state <= SCSP_RUN;
            SCSP_RUN:     state <= SCSP_RUN;
         endcase
      end
   end

   // Captured once, then frozen until reset
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mgmt_mode <= RST_MGMT_MODE;
         fpm_n     <= RST_FPM_N;
         polarity  <= RST_POLARITY;
      end else if (state == SCSP_CAPTURE) begin
         mgmt_mode <= strap_s2[2];
         fpm_n     <= strap_s2[1];
         polarity  <= strap_s2[0];
      end
   end

   // Pins stay inputs until the straps are held, so the capture never reads our own drive
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         status_on <= 1'h0;
      end else begin
         status_on <= (state == SCSP_RUN) && status_output_enable;
      end
   end

   // Mode strap pin reused as suspend status
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mgmt_mode_pin_out <= 1'h0;
         mgmt_mode_pin_oe  <= 1'h0;
      end else begin
         mgmt_mode_pin_oe  <= status_on;
         mgmt_mode_pin_out <= status_on && ss_suspended;
      end
   end

   // Power strap pin reused as connection status
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         full_power_mgmt_pin_out <= 1'h0;
         full_power_mgmt_pin_oe  <= 1'h0;
      end else begin
         full_power_mgmt_pin_oe  <= status_on;
         full_power_mgmt_pin_out <= status_on && ss_connected;
      end
   end

   // Open-drain serial pins steered by the captured mode
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         scl_pin_out <= 1'b0;
         scl_pin_oe  <= 1'b0;
         sda_pin_out <= 1'b0;
         sda_pin_oe  <= 1'b0;
      end else if (state != SCSP_RUN) begin
         // Open drain: the pins are only ever pulled low
         scl_pin_out <= 1'h0;
         sda_pin_out <= 1'h0;
         scl_pin_oe  <= 1'h0;
         sda_pin_oe  <= 1'h0;
      end else if (mgmt_mode == MGMT_I2C_MASTER) begin
         scl_pin_out <= 1'h0;
         sda_pin_out <= 1'h0;
         scl_pin_oe  <= master_scl_drive_low;
         sda_pin_oe  <= master_sda_drive_low;
      end else begin
         scl_pin_out <= 1'h0;
         sda_pin_out <= 1'h0;
         scl_pin_oe  <= 1'h0;                 // Host owns the clock
         sda_pin_oe  <= slave_sda_drive_low;
      end
   end

   // Mode outputs follow the captured strap only once running, so the core never sees the reset guess
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         straps_valid     <= 1'h0;
         i2c_master_mode  <= 1'h0;
         smbus_slave_mode <= 1'h0;
      end else begin
         straps_valid     <= (state == SCSP_RUN);
         i2c_master_mode  <= (state == SCSP_RUN) && (mgmt_mode == MGMT_I2C_MASTER);
         smbus_slave_mode <= (state == SCSP_RUN) && (mgmt_mode == MGMT_SMBUS_SLAVE);
      end
   end

   // Power configuration
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         power_switching_enabled <= 1'h0;
         power_ctrl_active_high  <= 1'h0;
      end else begin
         power_switching_enabled <= (state == SCSP_RUN) && (fpm_n == FPM_ENABLED);
         power_ctrl_active_high  <= (polarity == POL_ACTIVE_HIGH);
      end
   end

   // Slave address; only one bit depends on a strap, the rest is fixed
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         slave_addr <= SLAVE_ADDR_BASE;
      end else begin
         slave_addr <= SLAVE_ADDR_BASE;
         if (mgmt_mode == MGMT_SMBUS_SLAVE) begin
            slave_addr[SLAVE_ADDR_STRAP_BIT] <= fpm_n;
         end
      end
   end

   // Per-port power and charge outputs; power off is 0 in reset, 1 until capture, then the inactive level of the strapped polarity; charge off is 0
   genvar p;
   generate
      for (p = 0; p < NPORT; p++) begin : g_port
         // Power control; the off level depends on the strapped polarity
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               port_power_enable_out[p] <= 1'h0;
            end else begin
               port_power_enable_out[p] <= ((state == SCSP_RUN) && (fpm_n == FPM_ENABLED) && port_power_request[p])
                                           ~^ polarity;
            end
         end

         // Charge enable is active high whatever the polarity strap says
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               battery_charge_enable_out[p] <= 1'h0;
            end else begin
               battery_charge_enable_out[p] <= (state == SCSP_RUN) && (fpm_n == FPM_ENABLED)
                                               && port_charge_request[p];
            end
         end
      end
   endgenerate
endmodule // scsp_strap_capture

/* File: verilog/scsp_pkg.sv */
package scsp_pkg;
   // Sampled strap encodings
   localparam logic MGMT_I2C_MASTER  = 1'b1;
   localparam logic MGMT_SMBUS_SLAVE = 1'b0;
   localparam logic FPM_ENABLED      = 1'b0;
   localparam logic POL_ACTIVE_HIGH  = 1'b1;
   // Values held until the first capture after reset release
   localparam logic RST_MGMT_MODE    = 1'b1;
   localparam logic RST_FPM_N        = 1'b1;
   localparam logic RST_POLARITY     = 1'b0;
   // Number of downstream ports
   localparam int   NUM_PORTS        = 4;
   // Default slave address, bit 1 replaced by the strap
   localparam logic [6:0] SLAVE_ADDR_BASE = 7'h44;
   localparam int   SLAVE_ADDR_STRAP_BIT  = 1;
   typedef enum logic [1:0] {SCSP_RESET, SCSP_FILL, SCSP_CAPTURE, SCSP_RUN} scsp_state_t;
endpackage

/* File: sim/scsp_strap_capture_properties.sv */
`timescale 1ns/100ps
module scsp_strap_capture_properties import scsp_pkg::*; #(parameter int NPORT = NUM_PORTS) (
   // Clock, reset and hub core
   input wire logic             clk_sys, rstn, ss_suspended, ss_connected, master_scl_drive_low,
   input wire logic             slave_sda_drive_low,
   input wire logic [NPORT-1:0] port_power_request, port_charge_request,
   // Pins and captured configuration
   input wire logic             scl_pin_oe, sda_pin_oe, mgmt_mode_pin_out, mgmt_mode_pin_oe,
   input wire logic             full_power_mgmt_pin_out, full_power_mgmt_pin_oe, i2c_master_mode,
   input wire logic             smbus_slave_mode, power_switching_enabled, power_ctrl_active_high, straps_valid,
   input wire logic [6:0]       slave_addr,
   input wire logic [NPORT-1:0] port_power_enable_out, battery_charge_enable_out
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   AST_MODE_ONE: assert property (straps_valid |-> i2c_master_mode != smbus_slave_mode) else $error("mode clash");
   AST_SCL_IDLE: assert property (smbus_slave_mode |-> !scl_pin_oe) else $error("scl driven");
   AST_SDA_SLV: assert property (smbus_slave_mode && slave_sda_drive_low |=> sda_pin_oe) else $error("sda idle");
   AST_SCL_MST: assert property (i2c_master_mode && master_scl_drive_low |=> scl_pin_oe) else $error("scl idle");
   AST_SUSP: assert property (mgmt_mode_pin_oe |-> mgmt_mode_pin_out == $past(ss_suspended)) else $error("susp");
   AST_CONN: assert property (full_power_mgmt_pin_oe |-> full_power_mgmt_pin_out == $past(ss_connected)) else $error("conn");
   AST_ADDR: assert property (smbus_slave_mode |-> slave_addr[1] == !power_switching_enabled) else $error("addr");
   AST_HOLD: assert property (
      straps_valid |=> $stable(power_ctrl_active_high) && $stable(power_switching_enabled)
      && $stable(i2c_master_mode)) else $error("strap moved");
   AST_PWR: assert property (
      power_switching_enabled |=> port_power_enable_out == ($past(port_power_request)
      ^ {NPORT{!power_ctrl_active_high}})) else $error("power out");
   AST_PWR_OFF: assert property (
      straps_valid && !power_switching_enabled |=> port_power_enable_out == {NPORT{!power_ctrl_active_high}})
      else $error("power not off");
   AST_BAT_ON: assert property (
      power_switching_enabled |=> battery_charge_enable_out == $past(port_charge_request)) else $error("charge out");
   AST_BAT_OFF: assert property (
      straps_valid && !power_switching_enabled |=> battery_charge_enable_out == {NPORT{1'h0}})
      else $error("charge not off");
endmodule // scsp_strap_capture_properties
bind scsp_strap_capture scsp_strap_capture_properties #(.NPORT(NPORT)) chk (.clk_sys(clk_sys), .rstn(rstn),
   .ss_suspended(ss_suspended), .ss_connected(ss_connected), .master_scl_drive_low(master_scl_drive_low),
   .slave_sda_drive_low(slave_sda_drive_low), .port_power_request(port_power_request),
   .port_charge_request(port_charge_request), .scl_pin_oe(scl_pin_oe), .sda_pin_oe(sda_pin_oe),
   .mgmt_mode_pin_out(mgmt_mode_pin_out), .mgmt_mode_pin_oe(mgmt_mode_pin_oe),
   .full_power_mgmt_pin_out(full_power_mgmt_pin_out), .full_power_mgmt_pin_oe(full_power_mgmt_pin_oe),
   .i2c_master_mode(i2c_master_mode), .smbus_slave_mode(smbus_slave_mode), .slave_addr(slave_addr),
   .power_switching_enabled(power_switching_enabled), .power_ctrl_active_high(power_ctrl_active_high),
   .straps_valid(straps_valid), .port_power_enable_out(port_power_enable_out),
   .battery_charge_enable_out(battery_charge_enable_out));

/* File: sim/scsp_board.sv */
`timescale 1ns/100ps
// Board pulls; a strap pin reads back the device drive once its status output is on
module scsp_board (
   input  wire logic pull_mode, pull_fpm_n, pull_pol, mode_oe, mode_out, fpm_oe, fpm_out,
   output logic      mode_pin, fpm_pin, pol_pin
);
   assign mode_pin = mode_oe ? mode_out : pull_mode;
   assign fpm_pin  = fpm_oe ? fpm_out : pull_fpm_n;
   assign pol_pin  = pull_pol;
endmodule // scsp_board

/* File: sim/tb_strap_capture_status_pins.sv */
`timescale 1ns/100ps
module tb_strap_capture_status_pins;
   import scsp_pkg::*;
   logic       clk_sys = 0, rstn = 0, soe = 0, susp = 0, conn = 0, mscl = 1, msda = 0, ssda = 1, pm = 1, pf = 1, pp = 0;
   logic [3:0] preq = 4'hA, creq = 4'h6;
   wire        mp, fp, pol, mo, moe, fo, foe, scloe, sdaoe, i2c, smb, pse, pah, sv;
   wire  [6:0] addr;
   wire  [3:0] pwr, bat;
   int         err_total = 0, tests_run = 0, cyc = 0;
   always #20 clk_sys = ~clk_sys;
   scsp_board brd (.pull_mode(pm), .pull_fpm_n(pf), .pull_pol(pp), .mode_oe(moe), .mode_out(mo), .fpm_oe(foe),
      .fpm_out(fo), .mode_pin(mp), .fpm_pin(fp), .pol_pin(pol));
   scsp_strap_capture dut (.clk_sys(clk_sys), .rstn(rstn), .mgmt_mode_strap(mp), .full_power_mgmt_strap_n(fp),
      .power_ctrl_polarity_strap(pol), .mgmt_mode_pin_out(mo), .mgmt_mode_pin_oe(moe), .full_power_mgmt_pin_out(fo),
      .full_power_mgmt_pin_oe(foe), .status_output_enable(soe), .ss_suspended(susp), .ss_connected(conn),
      .port_power_request(preq), .port_charge_request(creq), .master_scl_drive_low(mscl),
      .master_sda_drive_low(msda), .slave_sda_drive_low(ssda), .scl_pin_out(), .scl_pin_oe(scloe), .sda_pin_out(),
      .sda_pin_oe(sdaoe), .i2c_master_mode(i2c), .smbus_slave_mode(smb), .power_switching_enabled(pse),
      .power_ctrl_active_high(pah), .slave_addr(addr), .straps_valid(sv), .port_power_enable_out(pwr),
      .battery_charge_enable_out(bat));
   task automatic check(string name, logic [7:0] exp, logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("Checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Reset with the given board straps; captured values settle by edge 4
   task automatic boot(logic [2:0] s);
      rstn = 0;
      soe = 0;
      {pm, pf, pp} = s;
      repeat (8) @(negedge clk_sys);
      rstn = 1;
      repeat (5) @(negedge clk_sys);
   endtask
   task automatic check_cfg(logic [2:0] s);
      check("config", {3'h0, s[2], !s[2], !s[1], s[0], 1'h1}, {3'h0, i2c, smb, pse, pah, sv});
      check("addr", {1'b0, SLAVE_ADDR_BASE[6:2], s[2] ? SLAVE_ADDR_BASE[1] : s[1], SLAVE_ADDR_BASE[0]}, {1'b0, addr});
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         print_verdict();
      end
   end
   initial begin
      @(negedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         boot(i[2:0]);
         check_cfg(i[2:0]);
         check("power", {4'h0, i[1] ? (i[0] ? 4'h0 : 4'hF) : (i[0] ? preq : ~preq)}, {4'h0, pwr});
         check("charge", {4'h0, i[1] ? 4'h0 : creq}, {4'h0, bat});
         check("serial", {6'h0, i[2], !i[2]}, {6'h0, scloe, sdaoe});
         // Status drive takes over the pins while the pulls flip; the straps must not follow
         soe = 1;
         susp = i[0];
         conn = !i[0];
         {pm, pf, pp} = ~i[2:0];
         repeat (4) @(negedge clk_sys);
         check("status", {4'h0, 1'b1, i[0], 1'b1, !i[0]}, {4'h0, moe, mo, foe, fo});
         check_cfg(i[2:0]);
         $display("Test %0d done", i);
      end
      print_verdict();
   end
endmodule // tb_strap_capture_status_pins
